/* File: shared/cfg_pkg.sv */
// Constants, layouts and helpers for the system-area configuration decoder.
package cfg_pkg;
	// System-area byte addresses.
	localparam logic [9:0] ADDR_IRQ_FIRST = 10'h3D5;
	localparam logic [9:0] ADDR_IRQ_LAST = 10'h3D6;
	localparam logic [9:0] ADDR_SC0 = 10'h3E0;
	localparam logic [9:0] ADDR_SC1 = 10'h3E1;
	localparam logic [9:0] ADDR_HW1A = 10'h3EE;
	localparam logic [9:0] ADDR_HW1B = 10'h3EF;
	localparam logic [9:0] ADDR_TUNNEL = 10'h3FC;
	localparam logic [9:0] ADDR_SET2 = 10'h3FD;
	// Field positions in the first hardware byte.
	localparam int SET1_ACCESS_BIT = 7;
	localparam int SET1_WTX_BIT = 6;
	localparam int SET1_TYPEB_RATE_BIT = 5;
	localparam int SET1_IDSRC_BIT = 4;
	localparam int SET1_RF_RATE_BIT = 3;
	localparam int SET1_PROTO_MSB = 2;
	localparam int HW1B_ADDR_MSB = 6;
	// Field positions in the tunnel byte and the second hardware byte.
	localparam int TUN_TUNNEL_POLL_COMMAND_LSB = 4;
	localparam int TUN_ANSWER_LSB = 0;
	localparam int SET2_EDGE_LSB = 6;
	localparam int SET2_RESP_LSB = 4;
	localparam int SET2_SEL_LSB = 0;
	localparam int XSEL_RF_WRITE = 3;
	localparam int XSEL_RF_READ = 2;
	localparam int XSEL_TX_DONE = 1;
	localparam int XSEL_FIELD = 0;
	// Default byte images.
	localparam logic [7:0] DEF_HW1A = 8'h2F;
	localparam logic [7:0] DEF_HW1B = 8'h54;
	localparam logic [6:0] DEF_TARGET_ADDR = 7'h54;
	localparam logic [7:0] DEF_TUNNEL = 8'h47;
	localparam logic [7:0] DEF_SET2 = 8'hA0;
	localparam logic [7:0] DEF_SC0 = 8'hAA;
	localparam logic [7:0] DEF_SC1 = 8'hFF;
	localparam logic [7:0] DEF_IRQ_FIRST = 8'h00;
	localparam logic [7:0] DEF_IRQ_LAST = 8'h3F;
	localparam logic [7:0] OUT_RANGE_BLOCK = 8'h00;
	localparam logic [7:0] MAX_BLOCK = 8'h3F;
	// Exponent limits and defaults.
	localparam logic [3:0] TUNNEL_POLL_COMMAND_EXP_MAX = 4'h8;
	localparam logic [3:0] TUNNEL_POLL_COMMAND_EXP_DEF = 4'h4;
	localparam logic [3:0] ANSWER_EXP_MAX = 4'hC;
	localparam logic [3:0] ANSWER_EXP_DEF = 4'h7;
	// Protocol select codes.
	localparam logic [2:0] PROTO_JIS = 3'h1;
	localparam logic [2:0] PROTO_B = 3'h2;
	localparam logic [2:0] PROTO_JIS_B = 3'h3;
	localparam logic [2:0] PROTO_A = 3'h4;
	localparam logic [2:0] PROTO_AB = 3'h6;
	localparam logic [2:0] PROTO_ALL = 3'h7;
	// Data-rate ceilings.
	localparam logic [1:0] RATE_106 = 2'h0;
	localparam logic [1:0] RATE_212 = 2'h1;
	localparam logic [1:0] RATE_424 = 2'h2;
	localparam logic [1:0] RATE_ANY = 2'h3;
	// Timing.
	localparam longint CLK_PERIOD_NS = 25;
	localparam longint T_TUNNEL_NS = 1024000;
	localparam longint T_EDGE_NS = 6160000;
	localparam longint T_RESP_NS = 24600000;
	localparam int TUNNEL_CYCLES = int'(T_TUNNEL_NS / CLK_PERIOD_NS);
	localparam int EDGE_CYCLES = int'(T_EDGE_NS / CLK_PERIOD_NS);
	localparam int RESP_CYCLES = int'(T_RESP_NS / CLK_PERIOD_NS);
	localparam int DIV_W = 20;
	localparam int TICK_W = 13;

	// Replaces an exponent above its limit by the default.
	function automatic logic [3:0] clamp_exp(input logic [3:0] v, input logic [3:0] lim,
		input logic [3:0] def);
		clamp_exp = (v > lim) ? def : v;
	endfunction

	// Replaces a block number beyond the last block by the fallback.
	function automatic logic [7:0] fix_block(input logic [7:0] v);
		fix_block = (v > MAX_BLOCK) ? OUT_RANGE_BLOCK : v;
	endfunction
endpackage

/* File: shared/timer_if.sv */
// Control and status of one timeout timer.
`timescale 1ns/1ps
interface timer_if;
	logic start;
	logic stop;
	logic [3:0] exponent;
	logic expired;
	logic running;
	modport ctl(output start, output stop, output exponent, input expired, input running);
	modport tmr(input start, input stop, input exponent, output expired, output running);
endinterface

/* File: tb/irq_host_model.sv */
// Host-side model: supplies the first hardware byte and acknowledges interrupts.
`timescale 1ns/1ps
module irq_host_model (
	// Clock and interrupt line
	input wire logic mclk_in,
	input wire logic irq_n_in,
	// Settings
	input wire logic [2:0] proto_in,
	input wire logic [7:0] ack_delay_in,
	// Host actions
	output logic irq_ack_out,
	output logic [7:0] set1_byte_out
);
	logic [7:0] wait_cnt = 8'h00;
	// Bit 5 is always one and bit 3 always zero, whatever else the host wants.
	assign set1_byte_out = {2'b01, 1'b1, 1'b1, 1'b0, proto_in};
	initial irq_ack_out = 1'b0;
	// A slow host leaves the line low for a while, which also exercises holding.
	always @(posedge mclk_in)
	begin
		irq_ack_out <= 1'b0;
		if (irq_n_in !== 1'b0)
			wait_cnt <= 8'h00;
		else if (!irq_ack_out && wait_cnt == ack_delay_in)
			irq_ack_out <= 1'b1;
		else if (!irq_ack_out)
			wait_cnt <= wait_cnt + 8'h01;
	end
endmodule

/* File: tb/rfid_system_config_decode_tb_top.sv */
// Self-checking bench for the configuration decoder.
`timescale 1ns/1ps
module rfid_system_config_decode_tb_top;
	import cfg_pkg::*;
	localparam int TB = 4;
	logic mclk_in = 0, rst_in = 1, wr = 0, srst = 0, wtxb = 1, tirq = 0, qans = 0, scl = 0;
	logic rsts = 0, cmd = 0, rfw = 0, rfr = 0, txd = 0, fld = 0, vld = 1, qsee = 0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wd = 8'h00, rfa = 8'h00, rfb = 8'h00, dly = 8'h05;
	logic [2:0] proto = 3'h7;
	logic [63:0] sid = 64'h0123456789ABCDEF;
	wire [63:0] cid;
	wire [7:0] rdat, img1, last, first;
	wire [15:0] code;
	wire [6:0] taddr;
	wire [3:0] en, sel, tmo;
	wire [2:0] psel;
	wire [1:0] bmax, jmax;
	wire wtxe, tbr, ids, rfl, bad, rej, irq_n, ack, amode;
	int mismatches = 0, num_checks = 0;

	rfid_system_config_decode #(.TUNNEL_BASE_CYCLES(TB), .EDGE_BASE_CYCLES(TB),
		.RESP_BASE_CYCLES(TB)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.cfg_wr_en_in(wr), .cfg_addr_in(addr), .cfg_wdata_in(wd), .cfg_rdata_out(rdat),
		.cfg_valid_in(vld), .self_reset_in(srst), .access_mode_bit_out(amode),
		.wait_extension_enable_out(wtxe), .typeb_rate_limit_out(tbr),
		.identifier_source_select_out(ids), .rf_rate_limit_out(rfl),
		.rf_protocol_select_out(psel), .jis_enable_out(en[3]), .typea_enable_out(en[2]),
		.typeb_enable_out(en[1]), .auto_detect_out(en[0]), .protocol_code_bad_out(bad),
		.typeb_max_rate_out(bmax), .jis_max_rate_out(jmax), .serial_target_address_out(taddr),
		.system_code_bytes_out(code), .card_identifier_out(cid),
		.extra_interrupt_select_out(sel), .interrupt_block_first_out(first),
		.interrupt_block_last_out(last), .wtx_block_in(wtxb), .wtx_reject_out(rej),
		.stored_identifier_in(sid), .tunnel_irq_in(tirq), .tunnel_poll_command_seen_in(qsee),
		.tunnel_poll_command_answered_in(qans), .answer_seen_in(1'b0), .tunnel_poll_command_timeout_out(tmo[0]),
		.answer_timeout_out(tmo[1]), .i2c_busy_in(1'b1), .scl_edge_in(scl),
		.resp_start_in(rsts), .host_read_req_in(1'b0), .edge_timeout_out(tmo[2]),
		.resp_timeout_out(tmo[3]), .cmd_done_in(cmd), .rf_write_start_in(rfw),
		.rf_read_done_in(rfr), .rf_read_first_in(rfa), .rf_read_last_in(rfb),
		.rf_tx_done_in(txd), .field_detect_in(fld), .irq_ack_in(ack), .interrupt_out_n(irq_n));
	irq_host_model i_host (.mclk_in(mclk_in), .irq_n_in(irq_n), .proto_in(proto),
		.ack_delay_in(dly), .irq_ack_out(ack), .set1_byte_out(img1));

	initial
	begin
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic summarize();
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic wbyte(input logic [9:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		pulse(wr);
		step(1);
	endtask
	task automatic rbyte(input logic [9:0] a, input logic [7:0] e);
		addr = a;
		step(1);
		chk("rdata", e, rdat);
	endtask
	task automatic reload();
		pulse(srst);
		step(1);
	endtask
	task automatic tmo_chk(ref logic s, input int i, input int n);
		int k;
		pulse(s);
		for (k = 1; k < n + 20 && tmo[i] !== 1'b1; k++)
			step(1);
		chk("timeout", n, k);
		if (k == n + 20)
			summarize();
	endtask
	task automatic irq_chk(ref logic s, input logic e);
		int k;
		pulse(s);
		chk("irq_n", !e, irq_n);
		for (k = 0; k < 40 && irq_n !== 1'b1; k++)
			step(1);
		chk("irq_release", 0, k == 40);
		if (k == 40)
			summarize();
	endtask

	initial
	begin
		logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
		logic [3:0] ens [6] = '{4'h8, 4'h2, 4'hB, 4'h4, 4'h7, 4'hF};
		int hits = 0;
		step(5);
		rst_in = 0;
		step(1);
		chk("wtx", 1'b0, wtxe);
		chk("tbr", 1'b1, tbr);
		chk("amode", 1'b0, amode);
		chk("ids", 1'b0, ids);
		chk("rfl", 1'b1, rfl);
		chk("proto", PROTO_ALL, psel);
		chk("taddr", 7'b1010100, taddr);
		chk("code", {DEF_SC0, DEF_SC1}, code);
		chk("sel", 4'h0, sel);
		chk("rej", 1'b1, rej);
		chk("cid", 64'h0, cid);
		chk("bmax", RATE_106, bmax);
		chk("jmax", RATE_212, jmax);
		wbyte(ADDR_HW1B, 8'hD5);
		// Both exponents out of range, so the defaults must be used.
		wbyte(ADDR_TUNNEL, 8'h9D);
		wbyte(ADDR_SET2, 8'h4F);
		wbyte(ADDR_SC0, 8'h12);
		wbyte(ADDR_SC1, 8'h34);
		wbyte(ADDR_IRQ_FIRST, 8'h10);
		wbyte(ADDR_IRQ_LAST, 8'h05);
		wbyte(ADDR_HW1A, img1);
		wbyte(10'h3E5, 8'h77);
		rbyte(ADDR_HW1B, 8'h55);
		rbyte(ADDR_TUNNEL, 8'h9D);
		rbyte(10'h3E5, 8'h00);
		chk("taddr", 7'h54, taddr);
		irq_chk(rfw, 1'b0);
		reload();
		chk("taddr", 7'h55, taddr);
		chk("code", 16'h1234, code);
		chk("rej", 1'b0, rej);
		chk("cid", sid, cid);
		chk("bmax", RATE_424, bmax);
		chk("jmax", RATE_ANY, jmax);
		chk("sel", 4'hF, sel);
		chk("last", 8'h10, last);
		chk("first", 8'h10, first);
		vld = 1'b0;
		reload();
		chk("taddr", 7'h54, taddr);
		chk("code", {DEF_SC0, DEF_SC1}, code);
		chk("sel", 4'h0, sel);
		vld = 1'b1;
		proto = 3'h0;
		step(1);
		wbyte(ADDR_HW1A, img1);
		reload();
		chk("bad", 1'b1, bad);
		for (int i = 0; i < 6; i++)
		begin
			proto = codes[i];
			step(1);
			wbyte(ADDR_HW1A, img1);
			reload();
			chk("enables", ens[i], en);
		end
		tmo_chk(tirq, 0, TB * 16 + 1);
		tmo_chk(qans, 1, TB * 128 + 1);
		tmo_chk(scl, 2, TB * 2 + 1);
		tmo_chk(rsts, 3, TB + 1);
		pulse(tirq);
		pulse(qsee);
		repeat (TB * 20)
		begin
			step(1);
			hits += (tmo[0] !== 1'b0);
		end
		chk("tunnel_poll_command_stop", 0, hits);
		irq_chk(cmd, 1'b1);
		dly = 8'h00;
		irq_chk(rfw, 1'b1);
		irq_chk(txd, 1'b1);
		irq_chk(fld, 1'b1);
		rfa = 8'h0F;
		rfb = 8'h10;
		irq_chk(rfr, 1'b1);
		rfa = 8'h20;
		rfb = 8'h21;
		irq_chk(rfr, 1'b0);
		summarize();
	end
endmodule

/* File: verilog/rfid_system_config_decode.sv */
// System-area configuration store, decode, timeouts and interrupt request.
//
// How it works
// R1: Hardware byte one holds access, wait-extension, rate limits, id source, protocol.
// R2: Wait-extension blocks are accepted only while the enable bit is one.
// R3: TypeB rate-limit bit caps TypeB at 424 kbps.
// R4: Software must always program the TypeB rate-limit bit to one.
// R5: TypeB rate-limit applies only while the RF rate-limit bit is zero.
// R6: Id source zero gives an all-zero identifier, one uses stored bytes.
// R7: RF rate-limit one caps TypeB at 106 and JIS at 212 kbps.
// R8: Software must always program the RF rate-limit bit to zero.
// R9: Protocol code enables JIS, TypeA, TypeB and auto-detection as tabled.
// R10: Target address defaults to 1010100.
// R11: Tunnel_poll_command wait is base times two to the tunnel_poll_command exponent, 0..8, default 4.
// R12: Answer wait is base times two to the answer exponent, 0..12, default 7.
// R13: Tunnel_poll_command exponent sits in the upper nibble, answer exponent in the lower.
// R14: I2C edge gap times out after base times two to the edge exponent.
// R15: Response wait after interrupt uses the response exponent, also between parts.
// R16: Edge exponent bits 7:6, response bits 5:4, extra interrupts bits 3:0.
// R17: Software should pick exponents with margin for the base tick error.
// R18: Extra sources are RF write, RF read, transmit done, field detect.
// R19: Each extra source is off at zero, on at one, all default off.
// R20: RF write interrupt asserts when a nonvolatile write begins.
// R21: RF read interrupt fires at response end for reads touching the block range.
// R22: A last block below the first block is replaced by the first.
// R23: Rewritten settings apply only after power-up or self-reset.
// R24: System code defaults to AA then FF.
`timescale 1ns/1ps
module rfid_system_config_decode
	import cfg_pkg::*;
#(
	parameter int unsigned TUNNEL_BASE_CYCLES = TUNNEL_CYCLES,
	parameter int unsigned EDGE_BASE_CYCLES = EDGE_CYCLES,
	parameter int unsigned RESP_BASE_CYCLES = RESP_CYCLES
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// System-area byte port
	input wire logic cfg_wr_en_in,
	input wire logic [9:0] cfg_addr_in,
	input wire logic [7:0] cfg_wdata_in,
	output logic [7:0] cfg_rdata_out,
	input wire logic cfg_valid_in,
	input wire logic self_reset_in,
	// Decoded hardware settings
	output logic access_mode_bit_out,
	output logic wait_extension_enable_out,
	output logic typeb_rate_limit_out,
	output logic identifier_source_select_out,
	output logic rf_rate_limit_out,
	output logic [2:0] rf_protocol_select_out,
	output logic jis_enable_out,
	output logic typea_enable_out,
	output logic typeb_enable_out,
	output logic auto_detect_out,
	output logic protocol_code_bad_out,
	output logic [1:0] typeb_max_rate_out,
	output logic [1:0] jis_max_rate_out,
	output logic [6:0] serial_target_address_out,
	output logic [15:0] system_code_bytes_out,
	output logic [63:0] card_identifier_out,
	output logic [3:0] extra_interrupt_select_out,
	output logic [7:0] interrupt_block_first_out,
	output logic [7:0] interrupt_block_last_out,
	// Wait-extension check
	input wire logic wtx_block_in,
	output logic wtx_reject_out,
	// Identifier bytes held elsewhere in the system area
	input wire logic [63:0] stored_identifier_in,
	// Tunnel-mode timing
	input wire logic tunnel_irq_in,
	input wire logic tunnel_poll_command_seen_in,
	input wire logic tunnel_poll_command_answered_in,
	input wire logic answer_seen_in,
	output logic tunnel_poll_command_timeout_out,
	output logic answer_timeout_out,
	// I2C timing
	input wire logic i2c_busy_in,
	input wire logic scl_edge_in,
	input wire logic resp_start_in,
	input wire logic host_read_req_in,
	output logic edge_timeout_out,
	output logic resp_timeout_out,
	// Interrupt events
	input wire logic cmd_done_in,
	input wire logic rf_write_start_in,
	input wire logic rf_read_done_in,
	input wire logic [7:0] rf_read_first_in,
	input wire logic [7:0] rf_read_last_in,
	input wire logic rf_tx_done_in,
	input wire logic field_detect_in,
	input wire logic irq_ack_in,
	output logic interrupt_out_n
);
	typedef struct packed
	{
		logic [7:0] sh_irq_first;
		logic [7:0] sh_irq_last;
		logic [7:0] sh_sc0;
		logic [7:0] sh_sc1;
		logic [7:0] sh_hw1a;
		logic [7:0] sh_hw1b;
		logic [7:0] sh_tunnel;
		logic [7:0] sh_set2;
		logic [7:0] act_irq_first;
		logic [7:0] act_irq_last;
		logic [7:0] act_sc0;
		logic [7:0] act_sc1;
		logic [7:0] act_hw1a;
		logic [7:0] act_hw1b;
		logic [7:0] act_tunnel;
		logic [7:0] act_set2;
		logic load_pending;
		logic irq_pending;
		logic [7:0] rdata;
	} cfg_state_s;

	localparam cfg_state_s ST_RESET = '{
		sh_irq_first: DEF_IRQ_FIRST, sh_irq_last: DEF_IRQ_LAST,
		sh_sc0: DEF_SC0, sh_sc1: DEF_SC1, sh_hw1a: DEF_HW1A, sh_hw1b: DEF_HW1B,
		sh_tunnel: DEF_TUNNEL, sh_set2: DEF_SET2,
		act_irq_first: DEF_IRQ_FIRST, act_irq_last: DEF_IRQ_LAST,
		act_sc0: DEF_SC0, act_sc1: DEF_SC1, act_hw1a: DEF_HW1A, act_hw1b: DEF_HW1B,
		act_tunnel: DEF_TUNNEL, act_set2: DEF_SET2,
		load_pending: 1'b1, irq_pending: 1'b0, rdata: 8'h00};

	cfg_state_s st_reg;
	cfg_state_s st_next;
	logic load_fire;
	logic [7:0] first_fix;
	logic [7:0] last_fix;
	logic [3:0] tunnel_poll_command_exp;
	logic [3:0] answer_exp;
	logic read_in_range;
	logic any_event;

	timer_if tunnel_poll_command_if();
	timer_if answer_if();
	timer_if edge_if();
	timer_if resp_if();

	// Power-up and self-reset are the only moments stored bytes become live.
	assign load_fire = st_reg.load_pending | self_reset_in; // [R23]

	always_comb
	begin
		st_next = st_reg;
		st_next.load_pending = 1'b0;
		case (cfg_addr_in)
			ADDR_IRQ_FIRST: st_next.rdata = st_reg.sh_irq_first;
			ADDR_IRQ_LAST: st_next.rdata = st_reg.sh_irq_last;
			ADDR_SC0: st_next.rdata = st_reg.sh_sc0;
			ADDR_SC1: st_next.rdata = st_reg.sh_sc1;
			ADDR_HW1A: st_next.rdata = st_reg.sh_hw1a;
			ADDR_HW1B: st_next.rdata = st_reg.sh_hw1b;
			ADDR_TUNNEL: st_next.rdata = st_reg.sh_tunnel;
			ADDR_SET2: st_next.rdata = st_reg.sh_set2;
			default: st_next.rdata = 8'h00;
		endcase
		if (cfg_wr_en_in)
		begin
			case (cfg_addr_in)
				ADDR_IRQ_FIRST: st_next.sh_irq_first = cfg_wdata_in;
				ADDR_IRQ_LAST: st_next.sh_irq_last = cfg_wdata_in;
				ADDR_SC0: st_next.sh_sc0 = cfg_wdata_in;
				ADDR_SC1: st_next.sh_sc1 = cfg_wdata_in;
				ADDR_HW1A: st_next.sh_hw1a = cfg_wdata_in; // [R1]
				ADDR_HW1B: st_next.sh_hw1b = {1'b0, cfg_wdata_in[HW1B_ADDR_MSB:0]}; // [R1]
				ADDR_TUNNEL: st_next.sh_tunnel = cfg_wdata_in;
				ADDR_SET2: st_next.sh_set2 = cfg_wdata_in;
				default: st_next.sh_set2 = st_reg.sh_set2;
			endcase
		end
		// An invalid system area falls back to every default on load.
		if (load_fire) // [R23]
		begin
			if (cfg_valid_in)
			begin
				st_next.act_irq_first = st_reg.sh_irq_first;
				st_next.act_irq_last = st_reg.sh_irq_last;
				st_next.act_sc0 = st_reg.sh_sc0;
				st_next.act_sc1 = st_reg.sh_sc1;
				st_next.act_hw1a = st_reg.sh_hw1a;
				st_next.act_hw1b = st_reg.sh_hw1b;
				st_next.act_tunnel = st_reg.sh_tunnel;
				st_next.act_set2 = st_reg.sh_set2;
			end
			else
			begin
				st_next.act_irq_first = DEF_IRQ_FIRST;
				st_next.act_irq_last = DEF_IRQ_LAST;
				st_next.act_sc0 = DEF_SC0; // [R24]
				st_next.act_sc1 = DEF_SC1; // [R24]
				st_next.act_hw1a = DEF_HW1A;
				st_next.act_hw1b = DEF_HW1B; // [R10]
				st_next.act_tunnel = DEF_TUNNEL;
				st_next.act_set2 = DEF_SET2; // [R19]
			end
		end
		// A new event in the acknowledge cycle keeps the request asserted.
		st_next.irq_pending = any_event | (st_reg.irq_pending & ~irq_ack_in); // [R20]
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			st_reg <= ST_RESET;
		else
			st_reg <= st_next;
	end

	assign cfg_rdata_out = st_reg.rdata;

	// Hardware byte one fields and system code.
	assign access_mode_bit_out = st_reg.act_hw1a[SET1_ACCESS_BIT]; // [R1]
	assign wait_extension_enable_out = st_reg.act_hw1a[SET1_WTX_BIT]; // [R1]
	assign typeb_rate_limit_out = st_reg.act_hw1a[SET1_TYPEB_RATE_BIT]; // [R1]
	assign identifier_source_select_out = st_reg.act_hw1a[SET1_IDSRC_BIT];
	assign rf_rate_limit_out = st_reg.act_hw1a[SET1_RF_RATE_BIT]; // [R1]
	assign rf_protocol_select_out = st_reg.act_hw1a[SET1_PROTO_MSB:0];
	assign serial_target_address_out = st_reg.act_hw1b[HW1B_ADDR_MSB:0]; // [R10]
	assign system_code_bytes_out = {st_reg.act_sc0, st_reg.act_sc1}; // [R24]

	assign wtx_reject_out = wtx_block_in & ~wait_extension_enable_out; // [R2]

	assign card_identifier_out = identifier_source_select_out ? stored_identifier_in
		: 64'h0000000000000000; // [R6]

	always_comb
	begin
		if (rf_rate_limit_out)
		begin
			typeb_max_rate_out = RATE_106; // [R7]
			jis_max_rate_out = RATE_212; // [R7]
		end
		else
		begin
			typeb_max_rate_out = typeb_rate_limit_out ? RATE_424 : RATE_ANY; // [R3] [R5]
			jis_max_rate_out = RATE_ANY;
		end
	end

	always_comb
	begin
		jis_enable_out = 1'b0;
		typea_enable_out = 1'b0;
		typeb_enable_out = 1'b0;
		auto_detect_out = 1'b0;
		protocol_code_bad_out = 1'b0;
		case (rf_protocol_select_out) // [R9]
			PROTO_JIS: jis_enable_out = 1'b1;
			PROTO_B: typeb_enable_out = 1'b1;
			PROTO_JIS_B:
			begin
				jis_enable_out = 1'b1;
				typeb_enable_out = 1'b1;
				auto_detect_out = 1'b1;
			end
			PROTO_A: typea_enable_out = 1'b1;
			PROTO_AB:
			begin
				typea_enable_out = 1'b1;
				typeb_enable_out = 1'b1;
				auto_detect_out = 1'b1;
			end
			PROTO_ALL:
			begin
				jis_enable_out = 1'b1;
				typea_enable_out = 1'b1;
				typeb_enable_out = 1'b1;
				auto_detect_out = 1'b1;
			end
			default: protocol_code_bad_out = 1'b1;
		endcase
	end

	// Tunnel and hardware byte two fields.
	assign tunnel_poll_command_exp = clamp_exp(st_reg.act_tunnel[TUN_TUNNEL_POLL_COMMAND_LSB+3:TUN_TUNNEL_POLL_COMMAND_LSB],
		TUNNEL_POLL_COMMAND_EXP_MAX, TUNNEL_POLL_COMMAND_EXP_DEF); // [R11] [R13]
	assign answer_exp = clamp_exp(st_reg.act_tunnel[TUN_ANSWER_LSB+3:TUN_ANSWER_LSB],
		ANSWER_EXP_MAX, ANSWER_EXP_DEF); // [R12] [R13]
	assign extra_interrupt_select_out = st_reg.act_set2[SET2_SEL_LSB+3:SET2_SEL_LSB]; // [R16]

	// Interrupt block range.
	assign first_fix = fix_block(st_reg.act_irq_first);
	assign last_fix = fix_block(st_reg.act_irq_last);
	assign interrupt_block_first_out = first_fix;
	assign interrupt_block_last_out = (last_fix < first_fix) ? first_fix : last_fix; // [R22]
	assign read_in_range = (rf_read_first_in <= interrupt_block_last_out)
		&& (rf_read_last_in >= interrupt_block_first_out); // [R21]

	assign any_event = cmd_done_in | tunnel_irq_in
		| (extra_interrupt_select_out[XSEL_RF_WRITE] & rf_write_start_in) // [R18] [R20]
		| (extra_interrupt_select_out[XSEL_RF_READ] & rf_read_done_in & read_in_range) // [R21]
		| (extra_interrupt_select_out[XSEL_TX_DONE] & rf_tx_done_in) // [R18]
		| (extra_interrupt_select_out[XSEL_FIELD] & field_detect_in); // [R19]
	assign interrupt_out_n = ~st_reg.irq_pending;

	// Timers; the base tick tolerance is left to software when picking exponents.
	assign tunnel_poll_command_if.start = tunnel_irq_in; // [R11]
	assign tunnel_poll_command_if.stop = tunnel_poll_command_seen_in;
	assign tunnel_poll_command_if.exponent = tunnel_poll_command_exp;
	assign answer_if.start = tunnel_poll_command_answered_in; // [R12]
	assign answer_if.stop = answer_seen_in;
	assign answer_if.exponent = answer_exp;
	assign edge_if.start = i2c_busy_in & scl_edge_in; // [R14]
	assign edge_if.stop = ~i2c_busy_in;
	assign edge_if.exponent = {2'b00, st_reg.act_set2[SET2_EDGE_LSB+1:SET2_EDGE_LSB]}; // [R16]
	assign resp_if.start = resp_start_in; // [R15]
	assign resp_if.stop = host_read_req_in;
	assign resp_if.exponent = {2'b00, st_reg.act_set2[SET2_RESP_LSB+1:SET2_RESP_LSB]}; // [R16]
	assign tunnel_poll_command_timeout_out = tunnel_poll_command_if.expired;
	assign answer_timeout_out = answer_if.expired;
	assign edge_timeout_out = edge_if.expired;
	assign resp_timeout_out = resp_if.expired;

	timeout_timer #(.BASE_CYCLES(TUNNEL_BASE_CYCLES)) u_tunnel_poll_command (.mclk_in(mclk_in),
		.rst_in(rst_in), .tif(tunnel_poll_command_if));
	timeout_timer #(.BASE_CYCLES(TUNNEL_BASE_CYCLES)) u_answer (.mclk_in(mclk_in),
		.rst_in(rst_in), .tif(answer_if));
	timeout_timer #(.BASE_CYCLES(EDGE_BASE_CYCLES)) u_edge (.mclk_in(mclk_in),
		.rst_in(rst_in), .tif(edge_if));
	timeout_timer #(.BASE_CYCLES(RESP_BASE_CYCLES)) u_resp (.mclk_in(mclk_in),
		.rst_in(rst_in), .tif(resp_if));

	property p_ident_zero;
		@(posedge mclk_in) disable iff (rst_in)
		!identifier_source_select_out |-> card_identifier_out == 64'h0000000000000000;
	endproperty
	a_ident_zero: assert property (p_ident_zero) else $error("identifier not zeroed"); // [R6]

	property p_proto_all;
		@(posedge mclk_in) disable iff (rst_in)
		rf_protocol_select_out == PROTO_ALL |-> jis_enable_out && typea_enable_out
			&& typeb_enable_out && auto_detect_out && !protocol_code_bad_out;
	endproperty
	a_proto_all: assert property (p_proto_all) else $error("full protocol set not enabled"); // [R9]

	property p_rf_rate;
		@(posedge mclk_in) disable iff (rst_in)
		rf_rate_limit_out |-> typeb_max_rate_out == RATE_106 && jis_max_rate_out == RATE_212;
	endproperty
	a_rf_rate: assert property (p_rf_rate) else $error("RF rate limit not applied"); // [R7]

	property p_typeb_rate;
		@(posedge mclk_in) disable iff (rst_in)
		!rf_rate_limit_out && typeb_rate_limit_out |-> typeb_max_rate_out == RATE_424;
	endproperty
	a_typeb_rate: assert property (p_typeb_rate) else $error("TypeB cap wrong"); // [R5]

	property p_hold_until_load;
		@(posedge mclk_in) disable iff (rst_in)
		!load_fire |=> $stable(serial_target_address_out) && $stable(system_code_bytes_out);
	endproperty
	a_hold_until_load: assert property (p_hold_until_load) else $error("setting changed live"); // [R23]

	property p_default_load;
		@(posedge mclk_in) disable iff (rst_in)
		load_fire && !cfg_valid_in |=> serial_target_address_out == DEF_TARGET_ADDR
			&& system_code_bytes_out == {DEF_SC0, DEF_SC1} && extra_interrupt_select_out == 4'h0;
	endproperty
	a_default_load: assert property (p_default_load) else $error("defaults not applied"); // [R10]

	property p_range_order;
		@(posedge mclk_in) disable iff (rst_in)
		interrupt_block_last_out >= interrupt_block_first_out;
	endproperty
	a_range_order: assert property (p_range_order) else $error("block range reversed"); // [R22]

	property p_write_irq;
		@(posedge mclk_in) disable iff (rst_in)
		rf_write_start_in && extra_interrupt_select_out[XSEL_RF_WRITE] |=> !interrupt_out_n;
	endproperty
	a_write_irq: assert property (p_write_irq) else $error("write interrupt missing"); // [R20]

	property p_no_spurious_irq;
		@(posedge mclk_in) disable iff (rst_in)
		interrupt_out_n && !any_event |=> interrupt_out_n;
	endproperty
	a_no_spurious_irq: assert property (p_no_spurious_irq) else $error("interrupt unprompted"); // [R19]

	property p_tunnel_poll_command_exp;
		@(posedge mclk_in) disable iff (rst_in)
		tunnel_poll_command_exp <= TUNNEL_POLL_COMMAND_EXP_MAX && answer_exp <= ANSWER_EXP_MAX;
	endproperty
	a_tunnel_poll_command_exp: assert property (p_tunnel_poll_command_exp) else $error("exponent out of range"); // [R12]

	property p_wtx;
		@(posedge mclk_in) disable iff (rst_in)
		wtx_block_in |-> wtx_reject_out == !wait_extension_enable_out;
	endproperty
	a_wtx: assert property (p_wtx) else $error("wait-extension check wrong"); // [R2]

	c_reload: cover property (@(posedge mclk_in) disable iff (rst_in) self_reset_in && cfg_valid_in);
	c_irq: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(interrupt_out_n));
	c_tunnel_poll_command_to: cover property (@(posedge mclk_in) disable iff (rst_in) tunnel_poll_command_timeout_out);
	c_read_irq: cover property (@(posedge mclk_in) disable iff (rst_in)
		rf_read_done_in && read_in_range);
endmodule

/* File: verilog/timeout_timer.sv */
// Timeout of base period times two to the power of an exponent.
`timescale 1ns/1ps
module timeout_timer
	import cfg_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = TUNNEL_CYCLES
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Control
	timer_if.tmr tif
);
	typedef struct packed
	{
		logic running;
		logic expired;
		logic [DIV_W-1:0] div;
		logic [TICK_W-1:0] ticks;
	} tmr_s;

	tmr_s st_reg;
	tmr_s st_next;
	logic [TICK_W-1:0] limit;

	assign limit = TICK_W'(1) << tif.exponent;
	assign tif.expired = st_reg.expired;
	assign tif.running = st_reg.running;

	always_comb
	begin
		st_next = st_reg;
		st_next.expired = 1'b0;
		if (tif.start)
		begin
			// A restart wins over a stop so divided accesses rearm cleanly.
			st_next.running = 1'b1;
			st_next.div = '0;
			st_next.ticks = '0;
		end
		else if (tif.stop)
			st_next.running = 1'b0;
		else if (st_reg.running)
		begin
			if (st_reg.div == DIV_W'(BASE_CYCLES - 1))
			begin
				st_next.div = '0;
				st_next.ticks = st_reg.ticks + TICK_W'(1);
				if (st_reg.ticks + TICK_W'(1) == limit)
				begin
					st_next.running = 1'b0;
					st_next.expired = 1'b1;
				end
			end
			else
				st_next.div = st_reg.div + DIV_W'(1);
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	property p_expire_ends_run;
		@(posedge mclk_in) disable iff (rst_in)
		st_reg.expired |-> !st_reg.running;
	endproperty
	a_expire_ends_run: assert property (p_expire_ends_run) else $error("timer ran on after expiry"); // [R11]

	property p_start_clears;
		@(posedge mclk_in) disable iff (rst_in)
		tif.start |=> st_reg.running && st_reg.ticks == '0 && !st_reg.expired;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("timer start did not rearm"); // [R15]
endmodule
